/* rtl/hpsc_map.svh */
`ifndef HPSC_MAP_SVH
`define HPSC_MAP_SVH
// code in the index register's select field that picks this register
`define HPSC_REG_CODE      6'h01
// half select codes
`define HPSC_HALF_CODE_A   2'h0
`define HPSC_HALF_CODE_B   2'h2
// field positions
`define HPSC_BIT_RMODE     11
`define HPSC_BIT_RPOL      10
`define HPSC_BIT_BMODE     9
`define HPSC_BIT_BANK_SEL  8
`define HPSC_BIT_BOOT      5
`define HPSC_BIT_CPU_ORD   1
`define HPSC_BIT_HOST_ORD  0
// writable bits, reserved bits that read one, and every defined bit
`define HPSC_WR_MASK       32'h00000F03
`define HPSC_RSV_ONES      32'h00000040
`define HPSC_DEF_MASK      32'h00000F63
`define HPSC_STORE_RESET   32'h00000000
// clock and edge-mode request hold time
`define HPSC_CLK_NS        40
`define HPSC_EDGE_HOLD_NS  200
`define HPSC_EDGE_HOLD_CYC \
   ((`HPSC_EDGE_HOLD_NS + `HPSC_CLK_NS - 1) / `HPSC_CLK_NS)
// edges after reset release before the boot pin is caught;
// the pin needs one edge in and one sync edge before it is read
`define HPSC_BOOT_CAP_CNT  2'h3
`endif

/* rtl/hpsc_pkg.sv */
package hpsc_pkg;
   // request pin modes {mode, polarity}
   typedef enum logic [1:0] {
      HPSC_REQ_LOW_LVL  = 2'b00,
      HPSC_REQ_HIGH_LVL = 2'b01,
      HPSC_REQ_FALL_EDG = 2'b10,
      HPSC_REQ_RISE_EDG = 2'b11
   } hpsc_req_mode_t;
   // buffer bank modes {bank mode, bank select}
   typedef enum logic [1:0] {
      HPSC_BANK_SHARE0 = 2'b00,
      HPSC_BANK_SHARE1 = 2'b01,
      HPSC_BANK_H0_C1  = 2'b10,
      HPSC_BANK_H1_C0  = 2'b11
   } hpsc_bank_mode_t;
   // edge request pulse states
   typedef enum logic {
      HPSC_EDGE_IDLE  = 1'b0,
      HPSC_EDGE_PULSE = 1'b1
   } hpsc_edge_state_t;
endpackage : hpsc_pkg

/* rtl/hpsc_bank_route.sv */
`timescale 1ns/1ps
`default_nettype none
module hpsc_bank_route (
   input  wire logic                     sys_clk,    // system clock
   input  wire logic                     arst_n,     // async reset, low
   input  wire hpsc_pkg::hpsc_bank_mode_t bank_mode, // bank mode field
   input  wire logic                     host_req,   // host buffer request
   input  wire logic                     cpu_req,    // cpu buffer request
   output logic                          host_grant, // host served
   output logic                          host_bank,  // bank host reaches
   output logic                          cpu_grant,  // cpu served
   output logic                          cpu_bank    // bank cpu reaches
);
   // route and arbitrate by bank mode
   always_comb begin
      host_grant = host_req;
      cpu_grant  = cpu_req;
      host_bank  = 1'b0;
      cpu_bank   = 1'b0;
      unique case (bank_mode)
         hpsc_pkg::HPSC_BANK_SHARE0: begin
            cpu_grant = cpu_req & ~host_req;
         end
         hpsc_pkg::HPSC_BANK_SHARE1: begin
            host_bank = 1'b1;
            cpu_bank  = 1'b1;
            cpu_grant = cpu_req & ~host_req;
         end
         hpsc_pkg::HPSC_BANK_H0_C1: begin
            cpu_bank = 1'b1;
         end
         hpsc_pkg::HPSC_BANK_H1_C0: begin
            host_bank = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_HOST_FIRST: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (!bank_mode[1] && host_req && cpu_req) |-> (host_grant && !cpu_grant))
      else $error("cpu served before host on shared bank");
   AST_SHARE_BANK: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !bank_mode[1] |-> (host_bank == bank_mode[0] && cpu_bank == bank_mode[0]))
      else $error("shared mode reaches wrong bank");
   AST_SPLIT_BANK: assert property (@(posedge sys_clk) disable iff (!arst_n)
      bank_mode[1] |-> (host_bank == bank_mode[0] && cpu_bank != bank_mode[0]
                        && cpu_grant == cpu_req))
      else $error("split mode routing wrong");
   COV_CONFLICT: cover property (@(posedge sys_clk) disable iff (!arst_n)
      !bank_mode[1] && host_req && cpu_req);
endmodule : hpsc_bank_route
`default_nettype wire

/* rtl/hpsc_status_ctrl.sv */
`include "hpsc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module hpsc_status_ctrl #(
   parameter int HOLD_CYC = `HPSC_EDGE_HOLD_CYC  // edge request hold
) (
   input  wire logic        sys_clk,             // 25 MHz clock
   input  wire logic        arst_n,              // async reset, low
   input  wire logic        cpu_sel,             // cpu register access
   input  wire logic        cpu_wr,              // cpu write, else read
   input  wire logic [31:0] cpu_wdata,           // cpu write data
   output logic      [31:0] cpu_rdata,           // cpu read data
   input  wire logic        host_cs_n,           // host chip select pin
   input  wire logic        host_reg_select_pin, // host register select
   input  wire logic        host_rd_n,           // host read strobe pin
   input  wire logic        host_wr_n,           // host write strobe pin
   input  wire logic [15:0] host_d_in,           // host data pins in
   output logic      [15:0] host_d_out,          // host data pins out
   output logic             host_d_oe,           // host data drive
   input  wire logic [5:0]  reg_select_field,    // index register select
   input  wire logic [1:0]  half_select_field,   // index register half
   input  wire logic        dma_req,             // internal request level
   output logic             dma_request_pin,     // request pin
   input  wire logic        boot_mode_pin,       // boot mode strap pin
   input  wire logic        host_ram_req,        // host buffer request
   input  wire logic        cpu_ram_req,         // cpu buffer request
   output logic             host_ram_grant,      // host buffer grant
   output logic             host_ram_bank,       // host buffer bank
   output logic             cpu_ram_grant,       // cpu buffer grant
   output logic             cpu_ram_bank,        // cpu buffer bank
   input  wire logic [31:0] cpu_ram_wdata,       // cpu data to buffer
   output logic      [31:0] ram_cpu_wdata,       // ordered data to buffer
   input  wire logic [31:0] ram_rdata,           // buffer read data
   output logic      [31:0] cpu_ram_rdata,       // ordered data to cpu
   output logic             host_byte_order,     // host order to others
   output logic             cpu_ram_little       // cpu order to buffer
);
   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] hpsc_swap(input logic [31:0] w,
                                             input logic        lit);
      hpsc_swap = lit ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
   endfunction : hpsc_swap

   function automatic logic hpsc_upper(input logic [1:0] code,
                                       input logic       swp);
      hpsc_upper = (code == `HPSC_HALF_CODE_A) ^ swp;
   endfunction : hpsc_upper

   logic [31:0] store_reg;
   logic [31:0] store_next;
   logic        boot_reg;
   logic [1:0]  boot_cnt_reg;
   logic [31:0] read_val;
   logic [1:0]  boot_sync_reg;
   logic [2:0]  cs_sync_reg;
   logic [2:0]  rs_sync_reg;
   logic [2:0]  rd_sync_reg;
   logic [2:0]  wr_sync_reg;
   logic [15:0] d_sync1_reg;
   logic [15:0] d_sync2_reg;
   logic        host_hit;
   logic        host_wr_hit;
   logic        host_rd_act;
   logic        host_upper;
   logic        req_d_reg;
   logic        req_rise;
   logic        pin_next;
   logic [7:0]  hold_cnt_reg;
   hpsc_pkg::hpsc_edge_state_t edge_state_reg;
   hpsc_pkg::hpsc_req_mode_t   req_mode;
   hpsc_pkg::hpsc_bank_mode_t  bank_mode;

   assign req_mode  = hpsc_pkg::hpsc_req_mode_t'(
                      store_reg[`HPSC_BIT_RMODE:`HPSC_BIT_RPOL]);
   assign bank_mode = hpsc_pkg::hpsc_bank_mode_t'(
                      store_reg[`HPSC_BIT_BMODE:`HPSC_BIT_BANK_SEL]);
   assign host_byte_order = store_reg[`HPSC_BIT_HOST_ORD];
   assign cpu_ram_little  = store_reg[`HPSC_BIT_CPU_ORD];

   ////////////////////////////////////////////////////////////////////////
   // host pin synchronisers, third stage only for edge detection
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_sync_reg <= 3'h7;
         rs_sync_reg <= 3'h7;
         rd_sync_reg <= 3'h7;
         wr_sync_reg <= 3'h7;
         d_sync1_reg <= 16'h0000;
         d_sync2_reg <= 16'h0000;
      end else begin
         cs_sync_reg <= {cs_sync_reg[1:0], host_cs_n};
         rs_sync_reg <= {rs_sync_reg[1:0], host_reg_select_pin};
         rd_sync_reg <= {rd_sync_reg[1:0], host_rd_n};
         wr_sync_reg <= {wr_sync_reg[1:0], host_wr_n};
         d_sync1_reg <= host_d_in;
         d_sync2_reg <= d_sync1_reg;
      end
   end

   // host decode: selected by index code with select pin low
   assign host_hit = !cs_sync_reg[1] && !rs_sync_reg[1] &&
                     reg_select_field == `HPSC_REG_CODE;
   assign host_wr_hit = host_hit && wr_sync_reg[1] && !wr_sync_reg[2];
   assign host_rd_act = host_hit && !rd_sync_reg[1];
   assign host_upper  = hpsc_upper(half_select_field,
                                   host_byte_order);
   assign host_d_oe   = host_rd_act;

   ////////////////////////////////////////////////////////////////////////
   // register writes: cpu word first, host half on top
   always_comb begin
      store_next = store_reg;
      if (cpu_sel && cpu_wr) begin
         store_next = cpu_wdata & `HPSC_WR_MASK;
      end
      if (host_wr_hit) begin
         if (host_upper) begin
            store_next[31:16] = d_sync2_reg;
         end else begin
            store_next[15:0] = d_sync2_reg;
         end
         store_next = store_next & `HPSC_WR_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         store_reg <= `HPSC_STORE_RESET;
      end else begin
         store_reg <= store_next;
      end
   end

   // read value with fixed reserved bits and boot flag
   assign read_val = (store_reg & `HPSC_WR_MASK) | `HPSC_RSV_ONES |
                     ({31'h0, boot_reg} << `HPSC_BIT_BOOT);

   // cpu read data, one cycle after the access
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_rdata <= `HPSC_RSV_ONES;
      end else if (cpu_sel && !cpu_wr) begin
         cpu_rdata <= read_val;
      end
   end

   // host read half, refreshed every cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         host_d_out <= 16'h0000;
      end else begin
         host_d_out <= host_upper ? read_val[31:16] : read_val[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // boot pin caught once after reset release
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_sync_reg <= 2'h0;
         boot_cnt_reg  <= 2'h0;
         boot_reg      <= 1'b0;
      end else begin
         boot_sync_reg <= {boot_sync_reg[0], boot_mode_pin};
         if (boot_cnt_reg != `HPSC_BOOT_CAP_CNT) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
            if (boot_cnt_reg + 2'h1 == `HPSC_BOOT_CAP_CNT) begin
               boot_reg <= boot_sync_reg[1];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request pin: level modes follow, edge modes pulse for hold time
   assign req_rise = dma_req && !req_d_reg;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_d_reg      <= 1'b0;
         edge_state_reg <= hpsc_pkg::HPSC_EDGE_IDLE;
         hold_cnt_reg   <= 8'h00;
      end else begin
         req_d_reg <= dma_req;
         unique case (edge_state_reg)
            hpsc_pkg::HPSC_EDGE_IDLE: begin
               if (req_mode[1] && req_rise) begin
                  edge_state_reg <= hpsc_pkg::HPSC_EDGE_PULSE;
                  hold_cnt_reg   <= 8'(HOLD_CYC - 2); // rise cycle counts
               end
            end
            hpsc_pkg::HPSC_EDGE_PULSE: begin
               if (hold_cnt_reg == 8'h00 || !req_mode[1]) begin
                  edge_state_reg <= hpsc_pkg::HPSC_EDGE_IDLE;
               end else begin
                  hold_cnt_reg <= hold_cnt_reg - 8'h01;
               end
            end
         endcase
      end
   end

   // active level per polarity, idle is its inverse
   always_comb begin
      unique case (req_mode)
         hpsc_pkg::HPSC_REQ_LOW_LVL:  pin_next = !dma_req;
         hpsc_pkg::HPSC_REQ_HIGH_LVL: pin_next = dma_req;
         hpsc_pkg::HPSC_REQ_FALL_EDG: pin_next =
            !(req_rise || edge_state_reg == hpsc_pkg::HPSC_EDGE_PULSE);
         hpsc_pkg::HPSC_REQ_RISE_EDG: pin_next =
            req_rise || edge_state_reg == hpsc_pkg::HPSC_EDGE_PULSE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dma_request_pin <= 1'b1;
      end else begin
         dma_request_pin <= pin_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // buffer routing and cpu byte order
   hpsc_bank_route u_route (
      .sys_clk    (sys_clk),
      .arst_n     (arst_n),
      .bank_mode  (bank_mode),
      .host_req   (host_ram_req),
      .cpu_req    (cpu_ram_req),
      .host_grant (host_ram_grant),
      .host_bank  (host_ram_bank),
      .cpu_grant  (cpu_ram_grant),
      .cpu_bank   (cpu_ram_bank)
   );

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ram_cpu_wdata <= 32'h00000000;
         cpu_ram_rdata <= 32'h00000000;
      end else begin
         ram_cpu_wdata <= hpsc_swap(cpu_ram_wdata, cpu_ram_little);
         cpu_ram_rdata <= hpsc_swap(ram_rdata, cpu_ram_little);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_RSV_READ: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (cpu_rdata & ~`HPSC_DEF_MASK) == 32'h0 && cpu_rdata[6] == 1'b1)
      else $error("reserved bits read wrong");
   AST_CPU_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (cpu_sel && cpu_wr && !host_wr_hit) ##1 (cpu_sel && !cpu_wr) |=>
      (cpu_rdata & `HPSC_WR_MASK) == ($past(cpu_wdata, 2) & `HPSC_WR_MASK))
      else $error("cpu write not read back");
   AST_RO_IGNORE: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (boot_cnt_reg == `HPSC_BOOT_CAP_CNT && (cpu_sel && cpu_wr || host_wr_hit))
      |=> $stable(boot_reg) && (store_reg & ~`HPSC_WR_MASK) == 32'h0)
      else $error("read-only bit written");
   AST_LEVEL_LOW: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (req_mode == hpsc_pkg::HPSC_REQ_LOW_LVL) |=>
      dma_request_pin == !$past(dma_req))
      else $error("low level request wrong");
   AST_EDGE_FALL: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (req_mode == hpsc_pkg::HPSC_REQ_FALL_EDG && req_rise &&
       edge_state_reg == hpsc_pkg::HPSC_EDGE_IDLE && HOLD_CYC == 5) ##1
      (req_mode == hpsc_pkg::HPSC_REQ_FALL_EDG) [*5] |->
      $past(dma_request_pin, 4) == 1'b0 && dma_request_pin == 1'b0 ##1
      dma_request_pin == 1'b1)
      else $error("falling edge request wrong length");
   AST_CPU_ORDER: assert property (@(posedge sys_clk) disable iff (!arst_n)
      arst_n && $stable(cpu_ram_little) |=> cpu_ram_rdata ==
      ($past(cpu_ram_little) ?
       {$past(ram_rdata[7:0]), $past(ram_rdata[15:8]),
        $past(ram_rdata[23:16]), $past(ram_rdata[31:24])} : $past(ram_rdata)))
      else $error("cpu buffer byte order wrong");
   AST_HOST_HALF: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (arst_n && half_select_field == `HPSC_HALF_CODE_B && !host_byte_order
       && $stable(read_val)) |=> host_d_out == $past(read_val[15:0]))
      else $error("host half mapping wrong");
   AST_BOOT_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
      boot_cnt_reg == `HPSC_BOOT_CAP_CNT |=> $stable(boot_reg))
      else $error("boot flag changed after capture");
   AST_HOST_SEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
      host_d_oe |-> !rs_sync_reg[1] && reg_select_field == `HPSC_REG_CODE)
      else $error("host driven without select");
   COV_CPU_RW: cover property (@(posedge sys_clk) disable iff (!arst_n)
      (cpu_sel && cpu_wr) ##1 (cpu_sel && !cpu_wr));
   COV_HOST_WR: cover property (@(posedge sys_clk) disable iff (!arst_n)
      host_wr_hit);
   COV_EDGE_REQ: cover property (@(posedge sys_clk) disable iff (!arst_n)
      edge_state_reg == hpsc_pkg::HPSC_EDGE_PULSE);
endmodule : hpsc_status_ctrl
`default_nettype wire

/* verif/hpsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// external host: loads the index fields, then strobes the data pins
module hpsc_host_model (
   input  wire logic        sys_clk,             // system clock
   output logic             host_cs_n,           // chip select, low
   output logic             host_reg_select_pin, // register select pin
   output logic             host_rd_n,           // read strobe, low
   output logic             host_wr_n,           // write strobe, low
   output logic      [15:0] host_d_in,           // data to the device
   output logic      [5:0]  reg_select_field,    // index select code
   output logic      [1:0]  half_select_field,   // index half code
   input  wire logic [15:0] host_d_out,          // data from the device
   input  wire logic        host_d_oe            // device drives data
);
   // idle pins at time zero
   initial begin
      host_cs_n = 1'b1;
      host_reg_select_pin = 1'b1;
      host_rd_n = 1'b1;
      host_wr_n = 1'b1;
      host_d_in = 16'h5A5A;
      reg_select_field = 6'h00;
      half_select_field = 2'h0;
   end
   // index first, then a write strobe with data held past its release
   task automatic host_write(input logic [5:0] code, input logic [1:0] half,
                             input logic pin, input logic [15:0] data);
      @(posedge sys_clk);
      reg_select_field    <= code;
      half_select_field   <= half;
      @(posedge sys_clk);
      host_cs_n           <= 1'b0;
      host_reg_select_pin <= pin;
      host_wr_n           <= 1'b0;
      host_d_in           <= data;
      repeat (3) @(posedge sys_clk);
      host_wr_n           <= 1'b1;
      repeat (4) @(posedge sys_clk);
      host_cs_n           <= 1'b1;
      host_reg_select_pin <= 1'b1;
      host_d_in           <= ~data; // released lines never keep old data
      repeat (3) @(posedge sys_clk);
   endtask : host_write
   // index first, then a read strobe held while waiting up to six edges for the device to drive
   task automatic host_read(input logic [5:0] code, input logic [1:0] half,
                            output logic [15:0] data, output logic seen);
      int i;
      seen = 1'b0;
      @(posedge sys_clk);
      reg_select_field    <= code;
      half_select_field   <= half;
      @(posedge sys_clk);
      host_cs_n           <= 1'b0;
      host_reg_select_pin <= 1'b0;
      host_rd_n           <= 1'b0;
      for (i = 0; i < 6 && !seen; i++) begin
         @(posedge sys_clk);
         #1 seen = (host_d_oe === 1'b1);
      end
      repeat (2) @(posedge sys_clk);
      #1 data = host_d_out;
      @(posedge sys_clk);
      host_rd_n           <= 1'b1;
      host_cs_n           <= 1'b1;
      host_reg_select_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask : host_read
endmodule : hpsc_host_model
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        sys_clk, arst_n, cpu_sel, cpu_wr, dma_req, boot_mode_pin;
   logic        host_cs_n, host_reg_select_pin, host_rd_n, host_wr_n;
   logic        host_d_oe, dma_request_pin, host_ram_req, cpu_ram_req;
   logic        host_ram_grant, host_ram_bank, cpu_ram_grant, cpu_ram_bank;
   logic        host_byte_order, cpu_ram_little, h_seen;
   logic [31:0] cpu_wdata, cpu_rdata, cpu_ram_wdata, ram_cpu_wdata;
   logic [31:0] ram_rdata, cpu_ram_rdata, rd_val;
   logic [15:0] host_d_in, host_d_out, h_val;
   logic [5:0]  reg_select_field;
   logic [1:0]  half_select_field, md, hc;
   int          errors, check_count, m, k;
   ////////////////////////////////////////////////////////////////////////
   hpsc_status_ctrl #(.HOLD_CYC(5)) hpsc_status_ctrl_inst (
      .sys_clk, .arst_n, .cpu_sel, .cpu_wr, .cpu_wdata, .cpu_rdata,
      .host_cs_n, .host_reg_select_pin, .host_rd_n, .host_wr_n, .host_d_in,
      .host_d_out, .host_d_oe, .reg_select_field, .half_select_field,
      .dma_req, .dma_request_pin, .boot_mode_pin, .host_ram_req,
      .cpu_ram_req, .host_ram_grant, .host_ram_bank, .cpu_ram_grant,
      .cpu_ram_bank, .cpu_ram_wdata, .ram_cpu_wdata, .ram_rdata,
      .cpu_ram_rdata, .host_byte_order, .cpu_ram_little);
   hpsc_host_model hpsc_host_model_inst (
      .sys_clk, .host_cs_n, .host_reg_select_pin, .host_rd_n, .host_wr_n,
      .host_d_in, .reg_select_field, .half_select_field, .host_d_out,
      .host_d_oe);
   ////////////////////////////////////////////////////////////////////////
   // clock and time-zero inputs
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic do_reset(input logic boot);
      @(posedge sys_clk);
      arst_n        <= 1'b0;
      boot_mode_pin <= boot;
      repeat (3) @(posedge sys_clk);
      arst_n        <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask : do_reset
   task automatic cpu_write(input logic [31:0] d);
      @(posedge sys_clk);
      cpu_sel   <= 1'b1;
      cpu_wr    <= 1'b1;
      cpu_wdata <= d;
      @(posedge sys_clk);
      cpu_sel   <= 1'b0;
   endtask : cpu_write
   task automatic cpu_read(output logic [31:0] d);
      @(posedge sys_clk);
      cpu_sel <= 1'b1;
      cpu_wr  <= 1'b0;
      @(posedge sys_clk);
      cpu_sel <= 1'b0;
      @(negedge sys_clk);
      d = cpu_rdata;
   endtask : cpu_read
   // watchdog well beyond the expected run
   initial begin
      #(20000 * 40);
      errors++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      errors = 0; check_count = 0; arst_n = 1'b0; cpu_sel = 1'b0;
      cpu_wr = 1'b0; cpu_wdata = 32'h0; dma_req = 1'b0; boot_mode_pin = 1'b1;
      host_ram_req = 1'b0; cpu_ram_req = 1'b0; cpu_ram_wdata = 32'h0;
      ram_rdata = 32'h0;
      do_reset(1'b1);
      cpu_read(rd_val); check(rd_val, 32'h00000060);
      boot_mode_pin <= 1'b0;
      cpu_read(rd_val); check(rd_val, 32'h00000060);
      cpu_write(32'hFFFFFFFF);
      cpu_read(rd_val); check(rd_val, 32'h00000F63);
      cpu_write(32'h00000002);
      @(posedge sys_clk);
      cpu_ram_wdata <= 32'h11223344;
      ram_rdata     <= 32'hA1B2C3D4;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check(ram_cpu_wdata, 32'h44332211);
      check(cpu_ram_rdata, 32'hD4C3B2A1);
      check({cpu_ram_little, host_byte_order}, 32'h2);
      cpu_write(32'h00000000);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check(ram_cpu_wdata, 32'h11223344);
      check(cpu_ram_rdata, 32'hA1B2C3D4);
      // host side: halves, order swap and refused accesses
      hpsc_host_model_inst.host_write(6'h01, 2'h2, 1'b0, 16'hFFFF);
      cpu_read(rd_val); check(rd_val, 32'h00000F63);
      check({host_byte_order}, 32'h1);
      hpsc_host_model_inst.host_read(6'h01, 2'h0, h_val, h_seen);
      check({h_seen, h_val}, 32'h10F63);
      hpsc_host_model_inst.host_read(6'h01, 2'h2, h_val, h_seen);
      check({h_seen, h_val}, 32'h10000);
      hpsc_host_model_inst.host_write(6'h02, 2'h0, 1'b0, 16'h0000);
      hpsc_host_model_inst.host_write(6'h01, 2'h0, 1'b1, 16'h0000);
      cpu_read(rd_val); check(rd_val, 32'h00000F63);
      hpsc_host_model_inst.host_read(6'h02, 2'h0, h_val, h_seen);
      check({h_seen}, 32'h0);
      hpsc_host_model_inst.host_write(6'h01, 2'h0, 1'b0, 16'h0000);
      hpsc_host_model_inst.host_read(6'h01, 2'h2, h_val, h_seen);
      check({h_seen, h_val}, 32'h10060);
      // every bank mode against each request pattern with at least one request
      for (m = 0; m < 4; m++) begin
         md = m[1:0];
         cpu_write({20'h0, 2'h0, md, 8'h00});
         for (k = 1; k < 4; k++) begin
            hc = k[1:0];
            @(posedge sys_clk);
            host_ram_req <= hc[1];
            cpu_ram_req  <= hc[0];
            @(negedge sys_clk);
            check({host_ram_grant, cpu_ram_grant, host_ram_bank & hc[1],
                   cpu_ram_bank & hc[0]}, {hc[1], hc[0] & (md[1] | ~hc[1]),
                   md[0] & hc[1], (md[0] ^ md[1]) & hc[0]});
         end
      end
      host_ram_req <= 1'b0;
      cpu_ram_req  <= 1'b0;
      // every request pin mode: idle, active, then level or pulse end
      for (m = 0; m < 4; m++) begin
         md = m[1:0];
         cpu_write({20'h0, md, 10'h000});
         repeat (8) @(posedge sys_clk);
         @(negedge sys_clk); check({dma_request_pin}, {~md[0]});
         @(posedge sys_clk) dma_req <= 1'b1;
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk); check({dma_request_pin}, {md[0]});
         repeat (6) @(posedge sys_clk);
         @(negedge sys_clk);
         check({dma_request_pin}, {md[0] ^ md[1]});
         @(posedge sys_clk) dma_req <= 1'b0;
      end
      // second reset with the boot strap low
      do_reset(1'b0);
      cpu_read(rd_val); check(rd_val, 32'h00000040);
      check({dma_request_pin}, 32'h1);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
